// *** hdl/tmr_ctrl_top.sv ***
// 8-bit timer with waveform mode control and two output compare channels
`include "tmr_params.svh"

module tmr_ctrl_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic io_space_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic timer_tick_i,
    input wire logic [7:0] compare_value_a_i,
    input wire logic [7:0] compare_value_b_i,
    input wire logic overflow_clear_i,
    output logic overflow_flag_o,
    output logic [2:0] clock_select_o,
    input wire logic port_data_a_i,
    input wire logic port_dir_a_i,
    input wire logic port_data_b_i,
    input wire logic port_dir_b_i,
    output logic pin_a_o,
    output logic pin_a_oe_o,
    output logic pin_b_o,
    output logic pin_b_oe_o,
    output logic compare_out_a_o,
    output logic compare_out_b_o
);
    // a register answers at its data offset, or at its I/O offset when the
    // access comes through the I/O space
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic io,
        input logic [7:0] data_ofs,
        input logic [7:0] io_ofs
    );
        reg_hit = io ? (addr == io_ofs) : (addr == data_ofs);
    endfunction

    logic [7:0] timer0_control_a;
    logic [7:0] timer0_control_b;
    logic [7:0] count_value;
    logic [7:0] compare_act_a;
    logic [7:0] compare_act_b;
    tmr_pkg::tmr_dir_t count_dir;

    tmr_wave_if wave ();

    // register decode
    wire hit_ctrl_a = reg_hit(addr_i, io_space_i, `TMR_CTRL_A_DATA, `TMR_CTRL_A_IO);
    wire hit_ctrl_b = reg_hit(addr_i, io_space_i, `TMR_CTRL_B_DATA, `TMR_CTRL_B_IO);
    wire hit_count = reg_hit(addr_i, io_space_i, `TMR_COUNT_DATA, `TMR_COUNT_IO);
    wire wr_ctrl_a = wr_i & hit_ctrl_a;
    wire wr_ctrl_b = wr_i & hit_ctrl_b;
    wire wr_count = wr_i & hit_count;

    // fields
    wire [1:0] chan_a_out_mode = timer0_control_a[`TMR_COMA_HI:`TMR_COMA_LO];
    wire [1:0] chan_b_out_mode = timer0_control_a[`TMR_COMB_HI:`TMR_COMB_LO];
    wire [1:0] wave_mode_low = timer0_control_a[`TMR_WGML_HI:`TMR_WGML_LO];
    wire wave_mode_high_bit = timer0_control_b[`TMR_WGMH_BIT];
    wire [2:0] wave_mode = {wave_mode_high_bit, wave_mode_low};

    // mode decode; the unused codes 4 and 6 fall back to normal counting
    wire mode_pc = (wave_mode == `TMR_MODE_PC_FF) | (wave_mode == `TMR_MODE_PC_OCR);
    wire mode_fast = (wave_mode == `TMR_MODE_FAST_FF) | (wave_mode == `TMR_MODE_FAST_OCR);
    wire top_from_a = (wave_mode == `TMR_MODE_CTC) | (wave_mode == `TMR_MODE_PC_OCR)
                      | (wave_mode == `TMR_MODE_FAST_OCR);
    wire [7:0] top_value = top_from_a ? compare_act_a : `TMR_MAX;

    tmr_pkg::tmr_kind_t wave_kind;
    assign wave_kind = mode_pc ? tmr_pkg::kind_pc
                     : (mode_fast ? tmr_pkg::kind_fast : tmr_pkg::kind_nonpwm);

    // counter position
    wire at_top = (count_value == top_value);
    wire at_bottom = (count_value == `TMR_BOTTOM);
    wire at_max = (count_value == `TMR_MAX);
    wire going_up = (count_dir == tmr_pkg::dir_up);
    wire [7:0] count_inc = 8'(count_value + `TMR_ONE);
    wire [7:0] count_dec = 8'(count_value - `TMR_ONE);

    // tick-qualified events
    wire single_wrap = timer_tick_i & ~mode_pc & at_top;
    wire pc_turn_top = timer_tick_i & mode_pc & going_up & at_top;
    wire pc_turn_bottom = timer_tick_i & mode_pc & ~going_up & at_bottom;

    // the count reaches TOP, then steps down on the next tick without holding it
    wire [7:0] pc_next = going_up ? (at_top ? count_dec : count_inc)
                                  : (at_bottom ? count_inc : count_dec);
    wire [7:0] ss_next = at_top ? `TMR_BOTTOM : count_inc;
    wire [7:0] tick_next = mode_pc ? pc_next : ss_next;
    wire [7:0] next_count = wr_count ? wdata_i
                          : (timer_tick_i ? tick_next : count_value);

    tmr_pkg::tmr_dir_t next_dir;
    assign next_dir = ~mode_pc ? tmr_pkg::dir_up
                    : (pc_turn_top ? tmr_pkg::dir_down
                    : (pc_turn_bottom ? tmr_pkg::dir_up : count_dir));

    // compare buffering: straight through in non-PWM, latched at TOP in
    // phase correct and at the wrap to BOTTOM in fast PWM
    wire compare_load = (wave_kind == tmr_pkg::kind_nonpwm)
                        | (mode_pc & pc_turn_top)
                        | (mode_fast & single_wrap);
    wire [7:0] next_act_a = compare_load ? compare_value_a_i : compare_act_a;
    wire [7:0] next_act_b = compare_load ? compare_value_b_i : compare_act_b;

    // overflow point per mode
    wire ovf_at_max = ~mode_pc & (wave_mode != `TMR_MODE_FAST_OCR) & at_max;
    wire ovf_at_top = (wave_mode == `TMR_MODE_FAST_OCR) & at_top;
    wire ovf_event = timer_tick_i & (ovf_at_max | ovf_at_top)
                     | pc_turn_bottom;
    // a new overflow in the clearing cycle keeps the flag set
    wire next_ovf = ovf_event | (overflow_flag_o & ~overflow_clear_i);

    // compare matches and forced matches
    wire match_a = timer_tick_i & (count_value == compare_act_a);
    wire match_b = timer_tick_i & (count_value == compare_act_b);
    wire force_ok = (wave_kind == tmr_pkg::kind_nonpwm);
    wire force_a = wr_ctrl_b & force_ok & wdata_i[`TMR_FOCA_BIT];
    wire force_b = wr_ctrl_b & force_ok & wdata_i[`TMR_FOCB_BIT];
    wire top_eq_a = (compare_act_a == top_value);
    wire top_eq_b = (compare_act_b == top_value);

    // register writes; unimplemented bits never store
    wire [7:0] next_ctrl_a = wr_ctrl_a ? (wdata_i & `TMR_CTRL_A_MASK) : timer0_control_a;
    wire [7:0] next_ctrl_b = wr_ctrl_b ? (wdata_i & `TMR_CTRL_B_MASK) : timer0_control_b;

    // read data; force bits and reserved bits read as zero
    wire [7:0] read_word = hit_ctrl_a ? timer0_control_a
                         : hit_ctrl_b ? timer0_control_b
                         : hit_count ? count_value
                         : `TMR_READ_IDLE;
    wire [7:0] next_rdata = rd_i ? read_word : `TMR_READ_IDLE;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer0_control_a <= `TMR_CTRL_A_RESET;
            timer0_control_b <= `TMR_CTRL_B_RESET;
        end else begin
            timer0_control_a <= next_ctrl_a;
            timer0_control_b <= next_ctrl_b;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_value <= `TMR_COUNT_RESET;
            count_dir <= tmr_pkg::dir_up;
        end else begin
            count_value <= next_count;
            count_dir <= next_dir;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            compare_act_a <= `TMR_BOTTOM;
            compare_act_b <= `TMR_BOTTOM;
        end else begin
            compare_act_a <= next_act_a;
            compare_act_b <= next_act_b;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag_o <= 1'b0;
            rdata_o <= `TMR_READ_IDLE;
        end else begin
            overflow_flag_o <= next_ovf;
            rdata_o <= next_rdata;
        end
    end

    // events for the output channels
    assign wave.kind = wave_kind;
    assign wave.high_bit = wave_mode_high_bit;
    // a match at BOTTOM counts as up-counting so that compare 0 stays low
    assign wave.counting_up = going_up | at_bottom;
    assign wave.wrap = single_wrap;
    assign wave.at_top = pc_turn_top;

    logic connect_a;
    logic connect_b;

    tmr_out_chan #(
        .TOGGLE_IN_PWM(1'b1)
    ) u_chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wave(wave),
        .mode_i(chan_a_out_mode),
        .match_i(match_a),
        .top_eq_i(top_eq_a),
        .force_i(force_a),
        .out_o(compare_out_a_o),
        .connect_o(connect_a)
    );

    tmr_out_chan #(
        .TOGGLE_IN_PWM(1'b0)
    ) u_chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wave(wave),
        .mode_i(chan_b_out_mode),
        .match_i(match_b),
        .top_eq_i(top_eq_b),
        .force_i(force_b),
        .out_o(compare_out_b_o),
        .connect_o(connect_b)
    );

    // pin takeover; the driver itself follows the port direction bit
    assign pin_a_o = connect_a ? compare_out_a_o : port_data_a_i;
    assign pin_a_oe_o = port_dir_a_i;
    assign pin_b_o = connect_b ? compare_out_b_o : port_data_b_i;
    assign pin_b_oe_o = port_dir_b_i;
    assign clock_select_o = timer0_control_b[`TMR_CS_HI:`TMR_CS_LO];
endmodule

// *** hdl/tmr_params.svh ***
// constants for the 8-bit timer waveform mode control block
// Summary of operation
// - control register A sits at data offset 0x44, I/O offset 0x24, resets zero.
// - nonzero channel A output mode hands the A pin to compare output A.
// - non-PWM modes: channel A 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM channel A: 10 clear on match/set at BOTTOM, 11 inverse.
// - PWM channel A mode 01 toggles on match only with high mode bit set.
// - fast PWM, compare A equals TOP with upper bit set: act at BOTTOM only.
// - phase-correct channel A: 10 clear on up match, set on down match; 11 inverse.
// - phase-correct, compare A equals TOP with upper bit set: act at TOP only.
// - nonzero channel B output mode hands the B pin to compare output B.
// - non-PWM modes: channel B 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM channel B: 10 clear on match/set at BOTTOM, 11 inverse; 01 reserved.
// - phase-correct channel B: 10 clear up, set down; 11 inverse; 01 reserved.
// - fast PWM, compare B equals TOP with upper bit set: act at BOTTOM only.
// - phase-correct, compare B equals TOP with upper bit set: act at TOP only.
// - low mode bits join control register B bit to form a 3-bit mode.
// - modes 0,1,3 have TOP 0xFF; 2,5,7 take TOP from compare A; 4,6 unused.
// - compare updates immediate in modes 0,2; at TOP phase-correct; at BOTTOM fast.
// - overflow sets at MAX in 0,2,3; at BOTTOM in 1,5; at TOP in 7.
// - high mode bit is bit 3 of control register B at offset 0x45.
// - phase-correct counts up to TOP, turns down on the next tick without pausing, counts down, repeats.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

`define TMR_CTRL_A_DATA 8'h44
`define TMR_CTRL_A_IO 8'h24
`define TMR_CTRL_B_DATA 8'h45
`define TMR_CTRL_B_IO 8'h25
`define TMR_COUNT_DATA 8'h46
`define TMR_COUNT_IO 8'h26

`define TMR_CTRL_A_RESET 8'h00
`define TMR_CTRL_B_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_CTRL_A_MASK 8'hf3
`define TMR_CTRL_B_MASK 8'h0f
`define TMR_READ_IDLE 8'h00

`define TMR_COMA_HI 7
`define TMR_COMA_LO 6
`define TMR_COMB_HI 5
`define TMR_COMB_LO 4
`define TMR_WGML_HI 1
`define TMR_WGML_LO 0
`define TMR_WGMH_BIT 3
`define TMR_FOCA_BIT 7
`define TMR_FOCB_BIT 6
`define TMR_CS_HI 2
`define TMR_CS_LO 0

`define TMR_MODE_NORMAL 3'h0
`define TMR_MODE_PC_FF 3'h1
`define TMR_MODE_CTC 3'h2
`define TMR_MODE_FAST_FF 3'h3
`define TMR_MODE_PC_OCR 3'h5
`define TMR_MODE_FAST_OCR 3'h7

`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

`define TMR_MAX 8'hff
`define TMR_BOTTOM 8'h00
`define TMR_ONE 8'h01

`endif

// *** hdl/tmr_pkg.sv ***
// types shared by the timer waveform blocks
package tmr_pkg;
    typedef enum logic [1:0] {
        kind_nonpwm,
        kind_fast,
        kind_pc
    } tmr_kind_t;

    typedef enum logic {
        dir_up,
        dir_down
    } tmr_dir_t;
endpackage

// *** hdl/tmr_wave_if.sv ***
// counter events shared from the timer core to the output channels
interface tmr_wave_if;
    tmr_pkg::tmr_kind_t kind;
    logic high_bit;
    logic counting_up;
    logic wrap;
    logic at_top;

    modport timer (
        output kind,
        output high_bit,
        output counting_up,
        output wrap,
        output at_top
    );

    modport chan (
        input kind,
        input high_bit,
        input counting_up,
        input wrap,
        input at_top
    );
endinterface

// *** hdl/tmr_out_chan.sv ***
// one output compare channel: waveform flip-flop and pin takeover
`include "tmr_params.svh"

module tmr_out_chan #(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    tmr_wave_if.chan wave,
    input wire logic [1:0] mode_i,
    input wire logic match_i,
    input wire logic top_eq_i,
    input wire logic force_i,
    output logic out_o,
    output logic connect_o
);
    wire is_toggle = (mode_i == `TMR_COM_TOGGLE);
    wire is_clear = (mode_i == `TMR_COM_CLEAR);
    wire is_set = (mode_i == `TMR_COM_SET);
    wire hi = mode_i[1];

    // non-PWM: a match or a forced match applies the mode directly
    wire np_event = match_i | force_i;
    wire np_set = np_event & is_set;
    wire np_clear = np_event & is_clear;
    wire np_toggle = np_event & is_toggle;

    // the toggle option in PWM needs the high mode bit; channel B has none
    wire pwm_toggle = TOGGLE_IN_PWM & wave.high_bit & is_toggle & match_i;

    // fast PWM: the wrap to BOTTOM outranks a match in the same tick,
    // so a compare value equal to TOP only ever acts at the wrap
    wire fp_set = (is_clear & wave.wrap) | (is_set & match_i & ~wave.wrap);
    wire fp_clear = (is_set & wave.wrap) | (is_clear & match_i & ~wave.wrap);

    // phase correct: compare value at TOP gives the down-count result at TOP
    wire pc_top_fix = hi & top_eq_i & wave.at_top;
    wire pc_up_match = match_i & wave.counting_up;
    wire pc_dn_match = match_i & ~wave.counting_up;
    wire pc_set = pc_top_fix ? is_clear : ((pc_up_match & is_set) | (pc_dn_match & is_clear));
    wire pc_clear = pc_top_fix ? is_set : ((pc_up_match & is_clear) | (pc_dn_match & is_set));

    wire is_np = (wave.kind == tmr_pkg::kind_nonpwm);
    wire is_fp = (wave.kind == tmr_pkg::kind_fast);
    wire do_set = is_np ? np_set : (is_fp ? fp_set : pc_set);
    wire do_clear = is_np ? np_clear : (is_fp ? fp_clear : pc_clear);
    wire do_toggle = is_np ? np_toggle : pwm_toggle;

    wire next_out = do_set ? 1'b1 : (do_clear ? 1'b0 : (do_toggle ? ~out_o : out_o));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= next_out;
        end
    end

    assign connect_o = (mode_i != `TMR_COM_OFF);
endmodule

// *** tb/tmr_pin_load.sv ***
// load on the two compare pins: a pull-down holds a released pin low
module tmr_pin_load (
    input wire logic [1:0] pin_i,
    input wire logic [1:0] oe_i,
    output logic [1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign level_o = pin_i & oe_i;
endmodule

// *** tb/tmr_ctrl_monitor.sv ***
// concurrent checks on the timer control block ports
module tmr_ctrl_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic io_space_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic timer_tick_i,
    input wire logic overflow_flag_o,
    input wire logic port_data_a_i,
    input wire logic port_dir_a_i,
    input wire logic port_data_b_i,
    input wire logic port_dir_b_i,
    input wire logic pin_a_o,
    input wire logic pin_a_oe_o,
    input wire logic pin_b_o,
    input wire logic pin_b_oe_o,
    input wire logic compare_out_a_o,
    input wire logic compare_out_b_o
);
    logic [7:0] ctl_a;
    wire logic sel_a = io_space_i ? addr_i == 8'h24 : addr_i == 8'h44;
    // shadow of control A, bits 3:2 never stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_a <= 8'h00;
        end else if (wr_i && sel_a) begin
            ctl_a <= wdata_i & 8'hf3;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd_a; rd_i && sel_a; endsequence
    sequence s_rd_hole; rd_i && !io_space_i && addr_i == 8'h10; endsequence
    property p_rd_a; s_rd_a |=> rdata_o == $past(ctl_a); endproperty
    property p_hole; s_rd_hole |=> rdata_o == 8'h00; endproperty
    property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    property p_oe; pin_a_oe_o == port_dir_a_i && pin_b_oe_o == port_dir_b_i; endproperty
    property p_pin_a;
        pin_a_o == ((ctl_a[7:6] != 2'h0) ? compare_out_a_o : port_data_a_i);
    endproperty
    property p_pin_b;
        pin_b_o == ((ctl_a[5:4] != 2'h0) ? compare_out_b_o : port_data_b_i);
    endproperty
    property p_ovf; $rose(overflow_flag_o) |-> $past(timer_tick_i); endproperty
    property p_cmp_a; $changed(compare_out_a_o) |-> $past(timer_tick_i || wr_i); endproperty
    property p_cmp_b; $changed(compare_out_b_o) |-> $past(timer_tick_i || wr_i); endproperty
    a_rd_a: assert property (p_rd_a) else $error("ctrl a readback wrong");
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    a_pin_a: assert property (p_pin_a) else $error("pin a source wrong");
    a_pin_b: assert property (p_pin_b) else $error("pin b source wrong");
    a_ovf: assert property (p_ovf) else $error("overflow without tick");
    a_cmp_a: assert property (p_cmp_a) else $error("output a moved idle");
    a_cmp_b: assert property (p_cmp_b) else $error("output b moved idle");
endmodule

bind tmr_ctrl_top tmr_ctrl_monitor tmr_ctrl_monitor_inst (
    .clk_i, .rst_i, .addr_i, .io_space_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .timer_tick_i, .overflow_flag_o, .port_data_a_i, .port_dir_a_i, .port_data_b_i,
    .port_dir_b_i, .pin_a_o, .pin_a_oe_o, .pin_b_o, .pin_b_oe_o, .compare_out_a_o,
    .compare_out_b_o
);

// *** tb/test_timer8_waveform_mode_control.sv ***
// bench: timer control block against an integer model of the counter
module test_timer8_waveform_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, cva = 8'h80, cvb = 8'h00, rdata;
    logic io_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, tick = 1'b0, ovc = 1'b0;
    logic [1:0] pd = 2'h0, dir = 2'h0, lvl;
    logic ovf, ca_o, cb_o, pa, pae, pb, pbe;
    logic [2:0] cs;
    int n_fail = 0, check_count = 0;
    int ctl_a, ctl_b, cnt, up, oa, ob, mf, ba, bb;
    always #2 clk_i = ~clk_i;
    tmr_ctrl_top tmr_ctrl_top_inst (.clk_i, .rst_i, .addr_i, .io_space_i(io_i), .wr_i,
        .rd_i, .wdata_i, .rdata_o(rdata), .timer_tick_i(tick), .compare_value_a_i(cva),
        .compare_value_b_i(cvb), .overflow_clear_i(ovc), .overflow_flag_o(ovf),
        .clock_select_o(cs), .port_data_a_i(pd[0]), .port_dir_a_i(dir[0]),
        .port_data_b_i(pd[1]), .port_dir_b_i(dir[1]), .pin_a_o(pa), .pin_a_oe_o(pae),
        .pin_b_o(pb), .pin_b_oe_o(pbe), .compare_out_a_o(ca_o), .compare_out_b_o(cb_o));
    tmr_pin_load tmr_pin_load_inst (.pin_i({pb, pa}), .oe_i({pbe, pae}), .level_o(lvl));
    function automatic int act(int md, int o, int up_m, int tg);
        if (md == 0) return o;
        if (md == 1) return tg ? !o : o;
        return (md == 3) ^ !up_m;
    endfunction
    function automatic bit hit(logic [7:0] ofs);
        return io_i ? addr_i == ofs - 8'h20 : addr_i == ofs;
    endfunction
    always @(posedge clk_i or posedge rst_i) begin : mdl
        int m, top, wa, eu;
        if (rst_i) begin
            {ctl_a, ctl_b, cnt, oa, ob, mf, ba, bb} = 256'h0;
            up = 1;
        end else begin
            m = {ctl_b[3], ctl_a[1:0]};
            top = (m == 2 || m == 5 || m == 7) ? ba : 255;
            if (ovc) mf = 0;
            if (tick && !m[0]) begin
                if (cnt == ba) oa = act(ctl_a[7:6], oa, 1, 1);
                if (cnt == bb) ob = act(ctl_a[5:4], ob, 1, 1);
                mf |= cnt == 255;
                cnt = (m == 2 && cnt == top) ? 0 : (cnt + 1) % 256;
            end else if (tick) begin
                wa = m[1] ? cnt == top : up && cnt == top;
                eu = m[1] || cnt == 0 || (up && !wa);
                if (cnt == ba) oa = act(ctl_a[7:6], oa, eu, m > 4);
                if (cnt == bb) ob = act(ctl_a[5:4], ob, eu, 0);
                if (m[1] && wa && ctl_a[7]) oa = !ctl_a[6];
                if (m[1] && wa && ctl_a[5]) ob = !ctl_a[4];
                mf |= m[1] ? wa : !up && cnt == 0;
                if (wa) begin
                    ba = cva;
                    bb = cvb;
                end
                if (m[1]) cnt = wa ? 0 : (cnt + 1) % 256;
                else begin
                    if (wa) up = 0;
                    else if (cnt == 0) up = 1;
                    cnt = (up ? cnt + 1 : cnt + 255) % 256;
                end
            end
            // non-PWM buffers follow the inputs once this tick has used them
            if (!m[0]) begin
                ba = cva;
                bb = cvb;
            end
            if (wr_i && hit(8'h44)) ctl_a = wdata_i & 8'hf3;
            if (wr_i && hit(8'h45)) ctl_b = wdata_i & 8'h0f;
        end
    end
    task automatic chk(logic [7:0] got, logic [7:0] exp, string w);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d, logic io);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        io_i = io;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic io, logic [7:0] exp);
        @(negedge clk_i);
        addr_i = a;
        io_i = io;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        chk(rdata, exp, "read");
    endtask
    task automatic step(int n);
        repeat (n) begin
            @(negedge clk_i);
            chk(ca_o, oa, "out a");
            chk(cb_o, ob, "out b");
            chk(ovf, mf, "overflow");
            chk(lvl, {dir[1] & (ctl_a[5:4] ? ob[0] : pd[1]),
                dir[0] & (ctl_a[7:6] ? oa[0] : pd[0])}, "pins");
            chk(cs, ctl_b[2:0], "clock select");
            if ($urandom % 32 == 0) cvb = 8'($urandom);
            tick = ($urandom % 4) != 0;
            ovc = ($urandom % 16) == 0;
            {pd, dir} = 4'($urandom);
        end
    endtask
    // channel b never gets the reserved code in the pwm runs
    task automatic run(int m, int am, int bm);
        @(negedge clk_i);
        rst_i = 1'b1;
        cvb = ($urandom % 2) ? cva : 8'($urandom);
        @(negedge clk_i);
        rst_i = 1'b0;
        wr(8'h44, {am[1:0], bm[1:0], 2'b11, m[1:0]}, 1'b0);
        wr(8'h25, {4'h0, m[2], 3'h1}, 1'b1);
        step(700);
    endtask
    initial begin
        void'($urandom(84));
        cva = 8'h80 + 8'($urandom % 127);
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h44, 1'b0, 8'h00);
        wr(8'h24, 8'hff, 1'b1);
        rd(8'h44, 1'b0, 8'hf3);
        wr(8'h45, 8'h0f, 1'b0);
        rd(8'h25, 1'b1, 8'h0f);
        rd(8'h10, 1'b0, 8'h00);
        run(0, 1 + $urandom % 3, 1 + $urandom % 3);
        run(2, 1 + $urandom % 3, 1 + $urandom % 3);
        run(3, 1 + $urandom % 3, 2 + $urandom % 2);
        run(7, 1 + $urandom % 3, 2 + $urandom % 2);
        run(1, 2 + $urandom % 2, 2 + $urandom % 2);
        wr(8'h45, 8'h09, 1'b0);
        step(900);
        stop_test;
    end
    initial begin
        #60000;
        n_fail++;
        stop_test;
    end
endmodule
